// [hw/synth_cfg_device.sv]
// Notes on behaviour
// RQ1: host writes words zero to four first
// RQ2: word3 enable bit0 one; bits1-3 words5-7
// RQ3: each optional word enabled independently
// RQ4: disabled optional word forced to default
// RQ5: defaults for words five, six, seven
// RQ6: word is data twenty bits, select four
// RQ7: word four field layout fixed
// RQ8: analog lock codes open-drain or push-pull
// RQ9: off, high, low, digital lock codes
// RQ10: divider outputs halved on codes twelve up
// RQ11: prescaler bit picks eight or sixteen
// RQ12: pump polarity one means positive
// RQ13: lock window adjust defaults to zero
// RQ14: auto wake clears power-down on word0
// RQ15: modulator order code decoding
// RQ16: dither level code decoding
// RQ17: doubler feeds main reference counter
// RQ18: msb first shift, latch commits word
//
// device end: shift register on link clock, word store on CLK
// assumes: latch_en is a level from the host, high after a word
// for at least two CLK periods
//
// Our own choices: strobed register access and the register addresses.
`default_nettype none
module synth_cfg_device (
  input wire logic CLK,
  input wire logic RESET,
  synth_cfg_if.device LINK,
  input wire logic CHIP_EN,
  input wire logic MAIN_DIGITAL_LOCK,
  input wire logic AUX_DIGITAL_LOCK,
  input wire logic MAIN_ANALOG_LOCK,
  input wire logic AUX_ANALOG_LOCK,
  input wire logic MAIN_REF_DIV,
  input wire logic MAIN_FB_DIV,
  input wire logic AUX_REF_DIV,
  input wire logic AUX_FB_DIV,
  output logic TEST_LOCK_PIN_O,
  output logic TEST_LOCK_PIN_OE,
  output logic CONFIGURED,
  output logic MAIN_POWER_DOWN,
  output logic AUX_POWER_DOWN,
  output logic AUX_PRESCALE_16,
  output logic MAIN_PUMP_POSITIVE,
  output logic AUX_PUMP_POSITIVE,
  output logic REF_DOUBLER_TO_MAIN,
  output logic REFERENCE_BUFFER_EN,
  output logic [2:0] MODULATOR_ORDER_NUM,
  output logic [1:0] DITHER_LEVEL,
  output logic LOCK_WINDOW_ADJUST,
  output logic [23:0] FRACTION_EXTENSION_WORD,
  output logic [23:0] FASTLOCK_SETUP_WORD,
  output logic [23:0] LOCK_AND_COUNTER_WORD
);
  ////////////////////////////////////////////////////////////////////////
  // link domain: shift in, capture on latch rising edge
  logic [23:0] shift;
  logic [23:0] held;
  always_ff @(posedge LINK.sclk) begin
    shift <= {shift[22:0], LINK.sdata}; // RQ18
  end
  always_ff @(posedge LINK.latch_en) begin
    held <= shift; // RQ18
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing: latch level synced, word stable long before edge seen
  logic latch_sync;
  logic latch_last;
  logic chip_en_sync;
  logic [3:0] lock_sync;
  logic [3:0] div_sync;
  synth_cfg_sync #(.WIDTH(1)) u_latch (
    .CLK(CLK), .RESET(RESET), .D(LINK.latch_en), .Q(latch_sync)
  );
  synth_cfg_sync #(.WIDTH(9)) u_misc (
    .CLK(CLK), .RESET(RESET),
    .D({CHIP_EN, MAIN_DIGITAL_LOCK, AUX_DIGITAL_LOCK, MAIN_ANALOG_LOCK,
        AUX_ANALOG_LOCK, MAIN_REF_DIV, MAIN_FB_DIV, AUX_REF_DIV,
        AUX_FB_DIV}),
    .Q({chip_en_sync, lock_sync, div_sync})
  );
  always_ff @(posedge CLK) begin
    if (RESET) latch_last <= 1'b0;
    else latch_last <= latch_sync;
  end
  logic commit;
  assign commit = latch_sync & ~latch_last;
  logic [3:0] sel;
  assign sel = held[synth_cfg_pkg::SEL_W-1:0]; // RQ6

  ////////////////////////////////////////////////////////////////////////
  // word store
  logic [23:0] word3;
  logic [23:0] word4;
  logic [23:0] user5;
  logic [23:0] user6;
  logic [23:0] user7;
  logic [4:0] seen;
  logic main_pd;
  logic aux_pd;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      word3 <= '0;
      word4 <= '0;
      user5 <= synth_cfg_pkg::DEF_W5;
      user6 <= synth_cfg_pkg::DEF_W6;
      user7 <= synth_cfg_pkg::DEF_W7;
    end else if (commit) begin
      case (sel)
        synth_cfg_pkg::SEL_W3: word3 <= held;
        synth_cfg_pkg::SEL_W4: word4 <= held; // RQ7
        synth_cfg_pkg::SEL_W5: user5 <= held;
        synth_cfg_pkg::SEL_W6: user6 <= held;
        synth_cfg_pkg::SEL_W7: user7 <= held;
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      seen <= '0;
    end else if (commit) begin
      case (sel)
        synth_cfg_pkg::SEL_W0: seen[0] <= 1'b1;
        synth_cfg_pkg::SEL_W1: seen[1] <= 1'b1;
        synth_cfg_pkg::SEL_W2: seen[2] <= 1'b1;
        synth_cfg_pkg::SEL_W3: seen[3] <= 1'b1;
        synth_cfg_pkg::SEL_W4: seen[4] <= 1'b1;
        default: ;
      endcase
    end
  end
  assign CONFIGURED = &seen; // RQ1
  // power-down bits of words 1 and 2, cleared by auto wake on word 0
  always_ff @(posedge CLK) begin
    if (RESET) begin
      main_pd <= 1'b0;
      aux_pd <= 1'b0;
    end else if (commit) begin
      if (sel == synth_cfg_pkg::SEL_W1)
        main_pd <= held[synth_cfg_pkg::PD_BIT];
      else if (sel == synth_cfg_pkg::SEL_W2)
        aux_pd <= held[synth_cfg_pkg::PD_BIT];
      else if (sel == synth_cfg_pkg::SEL_W0 && chip_en_sync &&
               word4[synth_cfg_pkg::AUTO_WAKE_BIT]) begin
        main_pd <= 1'b0; // RQ14
        aux_pd <= 1'b0; // RQ14
      end
    end
  end
  assign MAIN_POWER_DOWN = main_pd | ~chip_en_sync;
  assign AUX_POWER_DOWN = aux_pd | ~chip_en_sync;

  ////////////////////////////////////////////////////////////////////////
  // optional words: enable or default each one on its own
  logic [3:0] enables;
  assign enables = word3[synth_cfg_pkg::EN_LSB +: 4]; // RQ2
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FRACTION_EXTENSION_WORD <= synth_cfg_pkg::DEF_W5;
      FASTLOCK_SETUP_WORD <= synth_cfg_pkg::DEF_W6;
      LOCK_AND_COUNTER_WORD <= synth_cfg_pkg::DEF_W7;
    end else begin
      FRACTION_EXTENSION_WORD <= enables[1] ? user5 // RQ3
                                 : synth_cfg_pkg::DEF_W5; // RQ4 RQ5
      FASTLOCK_SETUP_WORD <= enables[2] ? user6
                             : synth_cfg_pkg::DEF_W6; // RQ4 RQ5
      LOCK_AND_COUNTER_WORD <= enables[3] ? user7
                               : synth_cfg_pkg::DEF_W7; // RQ4 RQ5
    end
  end
  assign LOCK_WINDOW_ADJUST =
    LOCK_AND_COUNTER_WORD[synth_cfg_pkg::LOCK_ADJ_BIT]; // RQ13

  ////////////////////////////////////////////////////////////////////////
  // word 4 decode
  logic [1:0] order_code;
  assign AUX_PRESCALE_16 = word4[synth_cfg_pkg::PRESCALE_BIT]; // RQ11
  assign MAIN_PUMP_POSITIVE = word4[synth_cfg_pkg::MAIN_POL_BIT]; // RQ12
  assign AUX_PUMP_POSITIVE = word4[synth_cfg_pkg::AUX_POL_BIT]; // RQ12
  assign REF_DOUBLER_TO_MAIN = word4[synth_cfg_pkg::DOUBLER_BIT]; // RQ17
  assign REFERENCE_BUFFER_EN = word4[synth_cfg_pkg::REFBUF_BIT];
  assign order_code =
    word4[synth_cfg_pkg::ORDER_MSB:synth_cfg_pkg::ORDER_LSB];
  always_comb begin
    case (order_code) // RQ15
      synth_cfg_pkg::ORD_FOURTH: MODULATOR_ORDER_NUM = 3'd4;
      synth_cfg_pkg::ORD_OFF: MODULATOR_ORDER_NUM = 3'd0;
      synth_cfg_pkg::ORD_SECOND: MODULATOR_ORDER_NUM = 3'd2;
      default: MODULATOR_ORDER_NUM = 3'd3;
    endcase
  end
  // reserved dither code treated as none
  assign DITHER_LEVEL =
    (word4[synth_cfg_pkg::DITHER_MSB:synth_cfg_pkg::DITHER_LSB] ==
     synth_cfg_pkg::DITHER_RESERVED) ? 2'd0 :
    word4[synth_cfg_pkg::DITHER_MSB:synth_cfg_pkg::DITHER_LSB]; // RQ16

  ////////////////////////////////////////////////////////////////////////
  // test/lock pin: dividers halved by toggles
  logic [3:0] half;
  logic [3:0] div_last;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_half
      always_ff @(posedge CLK) begin
        if (RESET) begin
          half[g] <= 1'b0;
          div_last[g] <= 1'b0;
        end else begin
          div_last[g] <= div_sync[g];
          if (div_sync[g] & ~div_last[g]) half[g] <= ~half[g]; // RQ10
        end
      end
    end
  endgenerate
  logic [3:0] pin_sel;
  logic pin_val;
  logic pin_od;
  logic pin_off;
  assign pin_sel = word4[synth_cfg_pkg::PIN_MSB:synth_cfg_pkg::PIN_LSB];
  always_comb begin
    pin_val = 1'b0;
    pin_od = (pin_sel >= 4'h6) && (pin_sel <= 4'h8); // RQ8
    pin_off = 1'b0;
    case (pin_sel)
      4'h0: pin_off = 1'b1; // RQ9
      4'h1: pin_val = 1'b1; // RQ9
      4'h2: pin_val = 1'b0; // RQ9
      4'h3: pin_val = lock_sync[3] & lock_sync[2]; // RQ9
      4'h4: pin_val = lock_sync[3];
      4'h5: pin_val = lock_sync[2];
      4'h6: pin_val = lock_sync[1] & lock_sync[0];
      4'h7: pin_val = lock_sync[1]; // RQ8
      4'h8: pin_val = lock_sync[0];
      4'h9: pin_val = lock_sync[1] & lock_sync[0]; // RQ8
      4'hA: pin_val = lock_sync[1];
      4'hB: pin_val = lock_sync[0];
      4'hC: pin_val = half[1]; // RQ10
      4'hD: pin_val = half[0];
      4'hE: pin_val = half[3];
      default: pin_val = half[2];
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TEST_LOCK_PIN_O <= 1'b0;
      TEST_LOCK_PIN_OE <= 1'b0;
    end else begin
      TEST_LOCK_PIN_O <= pin_od ? 1'b0 : pin_val;
      TEST_LOCK_PIN_OE <= ~pin_off & ~(pin_od & pin_val); // RQ8
    end
  end
endmodule : synth_cfg_device
`default_nettype wire

// [hw/synth_cfg_pkg.sv]
// constants shared by both ends of the three-wire configuration link
// assumes: 24-bit words, 4-bit select code in the low bits
`default_nettype none
package synth_cfg_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 4;
  localparam int CNT_W = 5;
  localparam logic [3:0] SEL_W0 = 4'h0;
  localparam logic [3:0] SEL_W1 = 4'h1;
  localparam logic [3:0] SEL_W2 = 4'h3;
  localparam logic [3:0] SEL_W3 = 4'h7;
  localparam logic [3:0] SEL_W4 = 4'h9;
  localparam logic [3:0] SEL_W5 = 4'hB;
  localparam logic [3:0] SEL_W6 = 4'hD;
  localparam logic [3:0] SEL_W7 = 4'hF;
  localparam logic [23:0] DEF_W5 = 24'h00_000B;
  localparam logic [23:0] DEF_W6 = 24'h00_000D;
  localparam logic [23:0] DEF_W7 = 24'h00_090F;
  // word 3 enable field
  localparam int EN_LSB = 20;
  // word 4 fields, then the word 7 lock adjust bit
  localparam int AUTO_WAKE_BIT = 23;
  localparam int FIXED_MSB = 22;
  localparam int FIXED_LSB = 19;
  localparam logic [3:0] FIXED_VAL = 4'h4;
  localparam int DITHER_MSB = 17;
  localparam int DITHER_LSB = 16;
  localparam int ORDER_MSB = 15;
  localparam int ORDER_LSB = 14;
  localparam int DOUBLER_BIT = 12;
  localparam int REFBUF_BIT = 11;
  localparam int AUX_POL_BIT = 10;
  localparam int MAIN_POL_BIT = 9;
  localparam int PRESCALE_BIT = 8;
  localparam int PIN_MSB = 7;
  localparam int PIN_LSB = 4;
  localparam int LOCK_ADJ_BIT = 13;
  // power-down bits in words 1 and 2 (select bits follow)
  localparam int PD_BIT = 22;
  // modulator order codes and the reserved dither code
  localparam logic [1:0] ORD_FOURTH = 2'h0;
  localparam logic [1:0] ORD_OFF = 2'h1;
  localparam logic [1:0] ORD_SECOND = 2'h2;
  localparam logic [1:0] ORD_THIRD = 2'h3;
  localparam logic [1:0] DITHER_RESERVED = 2'h3;
endpackage : synth_cfg_pkg
`default_nettype wire

// [hw/synth_cfg_if.sv]
// three-wire serial programming link between host and synthesizer
// assumes: host drives link clock, data and latch; device listens
`default_nettype none
interface synth_cfg_if;
  logic sclk;
  logic sdata;
  logic latch_en;
  modport host (output sclk, output sdata, output latch_en);
  modport device (input sclk, input sdata, input latch_en);
endinterface : synth_cfg_if
`default_nettype wire

// [hw/synth_cfg_sync.sv]
// two-stage synchroniser for single-bit levels
// assumes: destination clock CLK
`default_nettype none
module synth_cfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      meta <= '0;
      Q <= '0;
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule : synth_cfg_sync
`default_nettype wire

// [hw/synth_cfg_host.sv]
// host end: takes a 24-bit word from software and shifts it out
// assumes: CLK 100 MHz; link clock made by dividing CLK
`default_nettype none
module synth_cfg_host #(
  parameter int DIV_HALF = 2
) (
  input wire logic CLK,
  input wire logic RESET,
  synth_cfg_if.host LINK,
  input wire logic [1:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [23:0] RDATA
);
  typedef enum {IDLE, LOW, HIGH, LATCH} state_e;
  state_e state;
  logic [23:0] word;
  logic [4:0] bits;
  logic [7:0] tick;
  logic [23:0] last;
  logic [4:0] written;
  // address 0: write sends word; read 0 status, read 1 last word
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= IDLE;
      word <= '0;
      bits <= '0;
      tick <= '0;
      LINK.sclk <= 1'b0;
      LINK.sdata <= 1'b0;
      LINK.latch_en <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          LINK.latch_en <= 1'b0;
          if (WR && ADDR == 2'd0) begin
            word <= WDATA;
            bits <= 5'd23;
            tick <= '0;
            state <= LOW;
          end
        end
        LOW: begin
          LINK.sdata <= word[bits]; // RQ18
          LINK.sclk <= 1'b0;
          if (tick == 8'(DIV_HALF - 1)) begin
            tick <= '0;
            state <= HIGH;
          end else tick <= tick + 8'd1;
        end
        HIGH: begin
          LINK.sclk <= 1'b1;
          if (tick == 8'(DIV_HALF - 1)) begin
            tick <= '0;
            if (bits == 5'd0) state <= LATCH;
            else begin
              bits <= bits - 5'd1;
              state <= LOW;
            end
          end else tick <= tick + 8'd1;
        end
        LATCH: begin
          LINK.sclk <= 1'b0;
          LINK.latch_en <= 1'b1; // RQ18
          if (tick == 8'(DIV_HALF - 1)) state <= IDLE;
          else tick <= tick + 8'd1;
        end
        default: state <= IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      last <= '0;
      written <= '0;
    end else if (state == LATCH && tick == 8'(DIV_HALF - 1)) begin
      last <= word;
      case (word[3:0])
        synth_cfg_pkg::SEL_W0: written[0] <= 1'b1;
        synth_cfg_pkg::SEL_W1: written[1] <= 1'b1;
        synth_cfg_pkg::SEL_W2: written[2] <= 1'b1;
        synth_cfg_pkg::SEL_W3: written[3] <= 1'b1;
        synth_cfg_pkg::SEL_W4: written[4] <= 1'b1; // RQ1
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) RDATA <= '0;
    else if (RD) begin
      case (ADDR)
        2'd0: RDATA <= {17'd0, &written, written, state != IDLE};
        2'd1: RDATA <= last;
        default: RDATA <= '0;
      endcase
    end else RDATA <= '0;
  end
endmodule : synth_cfg_host
`default_nettype wire

// [tb/synth_cfg_sva.sv]
// link checks between the host end and the device end
// assumes: link signals sampled on the host clock, DIV_HALF of 2
`default_nettype none
module synth_cfg_sva (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_en
);
  logic [5:0] rises;
  logic sclk_q;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    sclk_q <= sclk;
  end
  // rising link clock edges since the last latch
  always_ff @(posedge CLK) begin
    if (RESET || latch_en) begin
      rises <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rises <= rises + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_clk_high;
    sclk [*2];
  endsequence
  sequence s_clk_low;
    !sclk [*2];
  endsequence
  a_sclk_shape: assert property (
    $rose(sclk) |-> s_clk_high ##1 s_clk_low)
    else $error("link clock high or low phase has wrong length");
  a_latch_len: assert property (
    $rose(latch_en) |-> latch_en [*2] ##1 !latch_en)
    else $error("latch pulse has wrong length");
  a_word_bits: assert property ($rose(latch_en) |-> rises == 6'h18)
    else $error("latch after a count of bits other than 24");
  a_data_hold: assert property (sclk |-> $stable(sdata))
    else $error("data changed while link clock high");
  a_latch_quiet: assert property (latch_en |-> !sclk)
    else $error("link clock high during latch");
  a_frame_idle: assert property ($fell(latch_en) |-> !sclk [*4])
    else $error("link clock moved right after a frame");
endmodule : synth_cfg_sva
`default_nettype wire

// [tb/tb.sv]
// bench: host end drives device end over the link, software port stimulus
// assumes: DIV_HALF 2, device store settles within 8 cycles of the latch
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int id; logic [23:0] exp;} note_s;
  localparam logic [3:0] SEL[3] = '{4'hB, 4'hD, 4'hF};
  localparam logic [23:0] DEF[3] = '{synth_cfg_pkg::DEF_W5,
    synth_cfg_pkg::DEF_W6, synth_cfg_pkg::DEF_W7};
  logic clk = 0, rst = 1, wr = 0, rd = 0, chip_en = 1, look = 0;
  logic [1:0] addr = '0;
  logic [23:0] wdata = '0, rdata, fx, fs, lw;
  logic [3:0] lock = '0, divs = '0;
  logic pin_o, pin_oe, cfg, mpd, apd, pre, mpol, apol, dbl, rbuf, lwa;
  logic [2:0] ordn;
  logic [1:0] dither;
  note_s q[$];
  note_s n;
  int fail_count = 0, total_checks = 0;
  string nm[9] = '{"frac", "fast", "lockw", "cfg", "pin", "w4", "pd", "lwa",
    "oe"};
  always #5 clk = ~clk;
  always @(posedge clk) divs <= 4'($urandom);
  ////////////////////////////////////////////////////////////////////////////
  synth_cfg_if synth_cfg_if_inst ();
  synth_cfg_host synth_cfg_host_inst (.CLK(clk), .RESET(rst),
    .LINK(synth_cfg_if_inst.host), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata));
  synth_cfg_device synth_cfg_device_inst (.CLK(clk), .RESET(rst),
    .LINK(synth_cfg_if_inst.device), .CHIP_EN(chip_en),
    .MAIN_DIGITAL_LOCK(lock[3]), .AUX_DIGITAL_LOCK(lock[2]),
    .MAIN_ANALOG_LOCK(lock[1]), .AUX_ANALOG_LOCK(lock[0]),
    .MAIN_REF_DIV(divs[3]), .MAIN_FB_DIV(divs[2]), .AUX_REF_DIV(divs[1]),
    .AUX_FB_DIV(divs[0]), .TEST_LOCK_PIN_O(pin_o),
    .TEST_LOCK_PIN_OE(pin_oe), .CONFIGURED(cfg), .MAIN_POWER_DOWN(mpd),
    .AUX_POWER_DOWN(apd), .AUX_PRESCALE_16(pre), .MAIN_PUMP_POSITIVE(mpol),
    .AUX_PUMP_POSITIVE(apol), .REF_DOUBLER_TO_MAIN(dbl),
    .REFERENCE_BUFFER_EN(rbuf), .MODULATOR_ORDER_NUM(ordn),
    .DITHER_LEVEL(dither), .LOCK_WINDOW_ADJUST(lwa),
    .FRACTION_EXTENSION_WORD(fx), .FASTLOCK_SETUP_WORD(fs),
    .LOCK_AND_COUNTER_WORD(lw));
  synth_cfg_sva synth_cfg_sva_inst (.CLK(clk), .RESET(rst),
    .sclk(synth_cfg_if_inst.sclk), .sdata(synth_cfg_if_inst.sdata),
    .latch_en(synth_cfg_if_inst.latch_en));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] seen(int id);
    case (id)
      0: return fx;
      1: return fs;
      2: return lw;
      3: return {23'h0, cfg};
      4: return {22'h0, pin_oe, pin_o};
      5: return {14'h0, pre, mpol, apol, dbl, rbuf, ordn, dither};
      6: return {22'h0, mpd, apd};
      7: return {23'h0, lwa};
      default: return {23'h0, pin_oe};
    endcase
  endfunction : seen
  function automatic logic [23:0] mk4(logic a, logic [8:0] r, logic [3:0] p);
    return {a, 4'h4, 1'b0, r[8:5], 1'b0, r[4:0], p, synth_cfg_pkg::SEL_W4};
  endfunction : mk4
  // {oe, o} of the test pin for codes below twelve
  function automatic logic [1:0] pin_exp(logic [3:0] c, logic [3:0] l);
    logic v;
    v = (c == 3) ? l[3] & l[2] : (c == 4) ? l[3] : (c == 5) ? l[2] :
      (c == 6 || c == 9) ? l[1] & l[0] : (c == 7 || c == 10) ? l[1] : l[0];
    if (c == 0) return 2'b00;
    if (c < 3) return {1'b1, c == 1};
    if (c > 5 && c < 9) return v ? 2'b00 : 2'b10;
    return {1'b1, v};
  endfunction : pin_exp
  task automatic check(string what, logic [23:0] got, logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic note(int id, logic [23:0] exp);
    q.push_back('{id, exp});
  endtask : note
  task automatic look_now(string t);
    @(posedge clk) look <= 1;
    @(posedge clk) look <= 0;
    $display("test %s done", t);
  endtask : look_now
  task automatic wr_reg(logic [1:0] a, logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
  endtask : wr_reg
  task automatic rd_reg(logic [1:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk) rd <= 0;
    @(negedge clk) d = rdata;
  endtask : rd_reg
  task automatic send(logic [23:0] w);
    logic [23:0] s;
    int k;
    wr_reg(2'h0, w);
    for (k = 0; k < 500; k++) begin
      rd_reg(2'h0, s);
      if (s[0] === 1'b0) break;
    end
    if (k == 500) begin
      fail_count++;
      end_of_test();
    end
    repeat (8) @(posedge clk);
  endtask : send
  always @(negedge clk) begin
    if (look) begin
      while (q.size() > 0) begin
        n = q.pop_front();
        check(nm[n.id], seen(n.id), n.exp);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] s, w, w4;
    int i, k, seed;
    seed = $urandom(32'h6ee8);
    repeat (20) @(posedge clk);
    rst <= 0;
    for (k = 0; k < 3; k++) note(k, DEF[k]);
    note(3, 24'h0);
    note(7, 24'h0);
    look_now("reset");
    send({20'($urandom), synth_cfg_pkg::SEL_W0});
    send({2'b01, 18'($urandom), synth_cfg_pkg::SEL_W1});
    send({2'b01, 18'($urandom), synth_cfg_pkg::SEL_W2});
    note(3, 24'h0);
    look_now("partial");
    send({4'b0001, 16'($urandom), synth_cfg_pkg::SEL_W3});
    send(mk4(1'b1, 9'($urandom), 4'h0));
    note(3, 24'h1);
    note(6, 24'h3);
    look_now("mandatory");
    rd_reg(2'h0, s);
    check("sent", {18'h0, s[6:1]}, 24'h3f);
    rd_reg(2'h3, s);
    check("unmapped", s, 24'h0);
    send({20'($urandom), synth_cfg_pkg::SEL_W0});
    note(6, 24'h0);
    look_now("wake");
    @(posedge clk) chip_en <= 0;
    send({2'b01, 18'($urandom), synth_cfg_pkg::SEL_W1});
    send({2'b01, 18'($urandom), synth_cfg_pkg::SEL_W2});
    send({20'($urandom), synth_cfg_pkg::SEL_W0});
    @(posedge clk) chip_en <= 1;
    repeat (8) @(posedge clk);
    note(6, 24'h3);
    look_now("chip off");
    for (i = 0; i < 8; i++) begin
      send({i[2:0], 1'b1, 16'($urandom), synth_cfg_pkg::SEL_W3});
      for (k = 0; k < 3; k++) begin
        w = {20'($urandom), SEL[k]};
        send(w);
        note(k, i[k] ? w : DEF[k]);
        if (k == 2) note(7, {23'h0, i[2] & w[13]});
      end
      look_now("optional");
    end
    for (i = 0; i < 16; i++) begin
      @(posedge clk) lock <= 4'($urandom);
      w4 = mk4(1'b0, 9'($urandom), i[3:0]);
      send(w4);
      if (i < 12) note(4, {22'h0, pin_exp(i[3:0], lock)});
      else note(8, 24'h1);
      note(5, {14'h0, w4[8], w4[9], w4[10], w4[12], w4[11],
        w4[15:14] == 0 ? 3'h4 : w4[15:14] == 1 ? 3'h0 : {1'b0, w4[15:14]},
        w4[17:16] == 3 ? 2'h0 : w4[17:16]});
      look_now("word4");
      rd_reg(2'h1, s);
      check("last", s, w4);
    end
    w4 = mk4(1'b0, 9'($urandom), 4'h1);
    wr_reg(2'h0, w4);
    send(mk4(1'b0, 9'($urandom), 4'h2));
    note(4, 24'h3);
    look_now("busy");
    rd_reg(2'h1, s);
    check("kept", s, w4);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
